// *** pkg/pmic_defs.svh ***
// Register offsets, field positions and reset values for the PMU register block
`ifndef PMIC_DEFS_SVH
`define PMIC_DEFS_SVH
`define PMIC_ADDR_STATUS_FIRST   8'h00
`define PMIC_ADDR_OVL_STATUS     8'h01
`define PMIC_ADDR_IRQ_EN_FIRST   8'h02
`define PMIC_ADDR_IRQ_EN_SECOND  8'h03
`define PMIC_ADDR_CHG_CTRL0      8'h04
`define PMIC_UNMAPPED_READ       8'hFF
`define PMIC_RST_OVL_STATUS      8'h00
`define PMIC_RST_IRQ_EN_FIRST    8'h00
`define PMIC_RST_IRQ_EN_SECOND   8'h00
`define PMIC_RST_CHG_CTRL0       8'h02
`define PMIC_EN_FIRST_WMASK      8'hFE
`define PMIC_CHG_CTRL0_WMASK     8'h7F
`define PMIC_SUPPLY_FLAG_MASK    8'h0E
`define PMIC_IRQ_BIT             0
`define PMIC_BAT_SCALE_BIT       6
`define PMIC_AC_SCALE_BIT        5
`define PMIC_TIMER_MSB           4
`define PMIC_TIMER_LSB           2
`define PMIC_EXT_GATE_BIT        1
`define PMIC_CHG_ON_BIT          0
`endif

// *** pkg/pmic_pkg.sv ***
// Types shared by the PMU register block
package pmic_pkg;
    typedef logic [7:0] pmic_byte_t;
    typedef logic [2:0] pmic_timer_t;
endpackage : pmic_pkg

// *** logic/pmic_regs.sv ***
// PMU interrupt status, enable and charger control registers
// What this block does
// - Read-only overload status: bits 7..1 switches seven..one, bit 0 converter three.
// - Overload flags set on rise, stay set, clear only on interrupt clear.
// - First enable register, bits 7..1 read-write, bit 0 reserved, reset 0.
// - Second enable register fully read-write, reset 0, one bit per flag.
// - Charger bits 6 and 5 scale battery and adapter limits, 0 full, 1 ninety.
// - Charger bits 4..2 pick fast-charge timer, reset code 000.
// - Charger bit 1 gates external charge control, resets to 1.
// - Charger bit 0 enables charger, resets 0; bit 7 reserved reads 0.
// - Status bit 0 reads 1 while interrupt asserted, 0 after clear.
// - Supply flags in the first group request interrupt on any change.
`include "pmic_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pmic_regs (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       rd_en_i,
    output logic      [7:0] rd_data_o,
    input  wire logic [7:0] first_cond_i,
    input  wire logic [7:0] ovl_cond_i,
    output logic            irq_o,
    output logic            bat_limit_scale_o,
    output logic            ac_limit_scale_o,
    output logic      [2:0] fast_timer_sel_o,
    output logic            ext_charge_gate_o,
    output logic            charger_on_o
);
    // first_cond_i bits 7..1: converter two/one overload, charge complete,
    // charge active, battery, system rail, adapter good; bit 0 unused.
    pmic_pkg::pmic_byte_t first_prev_q, ovl_prev_q;
    pmic_pkg::pmic_byte_t first_flag_q, ovl_flag_q;
    pmic_pkg::pmic_byte_t first_req_q, ovl_req_q;
    pmic_pkg::pmic_byte_t en_first_q, en_second_q, chg_ctrl_q;
    pmic_pkg::pmic_byte_t first_rise, first_chg, first_evt, ovl_rise;
    logic                 irq_q;
    logic                 wr_irq_clr;

    // Writing 0 to the summary bit clears every pending interrupt
    assign wr_irq_clr = wr_en_i && addr_i == `PMIC_ADDR_STATUS_FIRST
                        && !wr_data_i[`PMIC_IRQ_BIT];

    // Edge detection on the raw conditions
    assign first_rise = first_cond_i & ~first_prev_q;
    assign first_chg  = first_cond_i ^ first_prev_q;
    // Supply flags fire on either edge, overload flags on rise only
    assign first_evt  = ((first_chg & `PMIC_SUPPLY_FLAG_MASK)
                      | (first_rise & ~`PMIC_SUPPLY_FLAG_MASK))
                      & 8'hFE;
    assign ovl_rise   = ovl_cond_i & ~ovl_prev_q;

    // Previous condition samples
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_prev_q <= 8'h00;
            ovl_prev_q   <= 8'h00;
        end else begin
            first_prev_q <= first_cond_i;
            ovl_prev_q   <= ovl_cond_i;
        end
    end

    // Sticky overload flags; a new rise in the clear cycle wins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ovl_flag_q <= `PMIC_RST_OVL_STATUS;
        end else if (wr_irq_clr) begin
            ovl_flag_q <= ovl_rise;
        end else begin
            ovl_flag_q <= ovl_flag_q | ovl_rise;
        end
    end

    // First-group overload/complete flags sticky; supply flags live
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_flag_q <= 8'h00;
        end else if (wr_irq_clr) begin
            first_flag_q <= (first_cond_i & `PMIC_SUPPLY_FLAG_MASK)
                          | (first_rise & ~`PMIC_SUPPLY_FLAG_MASK & 8'hFE);
        end else begin
            first_flag_q <= (first_cond_i & `PMIC_SUPPLY_FLAG_MASK)
                          | (first_flag_q & ~`PMIC_SUPPLY_FLAG_MASK)
                          | (first_rise & 8'hFE);
        end
    end

    // Pending requests, kept until the interrupt clear; set wins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_req_q <= 8'h00;
            ovl_req_q   <= 8'h00;
        end else if (wr_irq_clr) begin
            first_req_q <= first_evt;
            ovl_req_q   <= ovl_rise;
        end else begin
            first_req_q <= first_req_q | first_evt;
            ovl_req_q   <= ovl_req_q | ovl_rise;
        end
    end

    // Summary interrupt from enabled requests only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(first_req_q & en_first_q) | |(ovl_req_q & en_second_q);
        end
    end
    assign irq_o = irq_q;

    // Enable registers; reserved bit 0 of the first stays 0
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            en_first_q  <= `PMIC_RST_IRQ_EN_FIRST;
            en_second_q <= `PMIC_RST_IRQ_EN_SECOND;
        end else if (wr_en_i) begin
            if (addr_i == `PMIC_ADDR_IRQ_EN_FIRST) begin
                en_first_q <= wr_data_i & `PMIC_EN_FIRST_WMASK;
            end
            if (addr_i == `PMIC_ADDR_IRQ_EN_SECOND) begin
                en_second_q <= wr_data_i;
            end
        end
    end

    // Charger control; bit 7 reserved, masked on write
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            chg_ctrl_q <= `PMIC_RST_CHG_CTRL0;
        end else if (wr_en_i && addr_i == `PMIC_ADDR_CHG_CTRL0) begin
            chg_ctrl_q <= wr_data_i & `PMIC_CHG_CTRL0_WMASK;
        end
    end

    // Charger outputs straight from the control flops
    assign bat_limit_scale_o = chg_ctrl_q[`PMIC_BAT_SCALE_BIT];
    assign ac_limit_scale_o  = chg_ctrl_q[`PMIC_AC_SCALE_BIT];
    assign fast_timer_sel_o  =
        chg_ctrl_q[`PMIC_TIMER_MSB:`PMIC_TIMER_LSB];
    assign ext_charge_gate_o = chg_ctrl_q[`PMIC_EXT_GATE_BIT];
    assign charger_on_o      = chg_ctrl_q[`PMIC_CHG_ON_BIT];

    // Registered read data; unmapped offsets read all ones
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_en_i) begin
            case (addr_i)
                `PMIC_ADDR_STATUS_FIRST:
                    rd_data_o <= {first_flag_q[7:1], irq_q};
                `PMIC_ADDR_OVL_STATUS:  rd_data_o <= ovl_flag_q;
                `PMIC_ADDR_IRQ_EN_FIRST:  rd_data_o <= en_first_q;
                `PMIC_ADDR_IRQ_EN_SECOND: rd_data_o <= en_second_q;
                `PMIC_ADDR_CHG_CTRL0:   rd_data_o <= chg_ctrl_q;
                default:                rd_data_o <= `PMIC_UNMAPPED_READ;
            endcase
        end
    end

    // Checks on the register behaviour
    a_ovl_sticky_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        ovl_flag_q[0] && !wr_irq_clr |=> ovl_flag_q[0])
        else $error("overload flag dropped without clear");
    a_ovl_rise_set: assert property (@(posedge clk_i) disable iff (reset_i)
        ovl_rise[3] |=> ovl_flag_q[3])
        else $error("overload rise not flagged");
    a_irq_masked_off: assert property (@(posedge clk_i) disable iff (reset_i)
        (en_first_q == 8'h00 && en_second_q == 8'h00)[*2] |-> !irq_o)
        else $error("interrupt with all enables off");
    a_irq_enabled_on: assert property (@(posedge clk_i) disable iff (reset_i)
        ovl_rise[0] && en_second_q[0] && !wr_irq_clr |=> ##1 irq_o)
        else $error("enabled event missed interrupt");
    a_supply_any_edge: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(first_cond_i[1]) |-> first_evt[1])
        else $error("supply fall gave no request");
    a_en_first_rsvd: assert property (@(posedge clk_i) disable iff (reset_i)
        !en_first_q[0])
        else $error("reserved enable bit set");
    a_chg_rsvd_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        !chg_ctrl_q[7])
        else $error("reserved charger bit set");
    a_chg_write_take: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_en_i && addr_i == `PMIC_ADDR_CHG_CTRL0 |=>
        fast_timer_sel_o == $past(wr_data_i[4:2])
        && charger_on_o == $past(wr_data_i[0]))
        else $error("charger control write lost");
    a_ext_gate_reset: assert property (@(posedge clk_i)
        $fell(reset_i) |-> ext_charge_gate_o && !charger_on_o)
        else $error("charger reset values wrong");

    // Clear steps: the strobe, then empty requests, then a quiet line.
    // Events landing after the strobe cannot hide the drop, since the
    // summary flop lags the request flops by one cycle.
    sequence s_irq_clear_write;
        wr_irq_clr && ovl_rise == 8'h00 && first_evt == 8'h00;
    endsequence
    sequence s_irq_quiet_after;
        ##1 (ovl_req_q == 8'h00 && first_req_q == 8'h00) ##1 !irq_o;
    endsequence
    a_clear_drops_irq: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s_irq_clear_write |-> s_irq_quiet_after)
        else $error("interrupt survived its clear");
    a_en_second_take: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_en_i && addr_i == `PMIC_ADDR_IRQ_EN_SECOND |=>
        en_second_q == $past(wr_data_i))
        else $error("second enable write lost");
    a_ovl_ro_write: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_en_i && addr_i == `PMIC_ADDR_OVL_STATUS && ovl_rise == 8'h00
        |=> ovl_flag_q == $past(ovl_flag_q))
        else $error("write changed read-only status");
    a_ovl_read_back: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rd_en_i && addr_i == `PMIC_ADDR_OVL_STATUS |=>
        rd_data_o == $past(ovl_flag_q))
        else $error("status read returned wrong value");
    a_scale_follow: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_en_i && addr_i == `PMIC_ADDR_CHG_CTRL0 |=>
        bat_limit_scale_o == $past(wr_data_i[6])
        && ac_limit_scale_o == $past(wr_data_i[5]))
        else $error("limit scale write lost");
endmodule : pmic_regs
`default_nettype wire

// *** test/pmic_host.sv ***
// Host model issuing single-byte register accesses to the PMU block
`timescale 1ns/1ps
`default_nettype none
module pmic_host (
    input  wire logic       clk_i,
    output logic      [7:0] addr_o,
    output logic            wr_en_o,
    output logic      [7:0] wr_data_o,
    output logic            rd_en_o
);
    // Idle port at time zero
    initial begin
        addr_o    = 8'h00;
        wr_en_o   = 1'h0;
        wr_data_o = 8'h00;
        rd_en_o   = 1'h0;
    end

    // One access, strobe held for exactly one taking edge
    task automatic acc(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk_i);
        addr_o    <= a;
        wr_data_o <= d;
        wr_en_o   <= wr;
        rd_en_o   <= !wr;
        @(posedge clk_i);
        wr_en_o <= 1'h0;
        rd_en_o <= 1'h0;
    endtask : acc
endmodule : pmic_host
`default_nettype wire

// *** test/pmic_regs_test.sv ***
// Self-checking bench for the PMU register block
`timescale 1ns/1ps
`default_nettype none
module pmic_regs_test;
    logic       clk_i, reset_i, wr_en, rd_en, irq, bs, as, eg, co;
    logic [7:0] addr, wr_data, rd_data, first_cond, ovl_cond, d, en;
    logic [2:0] ft;
    logic [31:0] seed = 32'h5072;
    int          err_total = 0, tests_run = 0, cyc = 0;

    pmic_host host (.clk_i(clk_i), .addr_o(addr), .wr_en_o(wr_en),
        .wr_data_o(wr_data), .rd_en_o(rd_en));
    pmic_regs dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr),
        .wr_en_i(wr_en), .wr_data_i(wr_data), .rd_en_i(rd_en),
        .rd_data_o(rd_data), .first_cond_i(first_cond),
        .ovl_cond_i(ovl_cond), .irq_o(irq), .bat_limit_scale_o(bs),
        .ac_limit_scale_o(as), .fast_timer_sel_o(ft),
        .ext_charge_gate_o(eg), .charger_on_o(co));

    // 100 MHz clock
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask : chk

    // Read data is registered, so it is looked at just after the edge
    task automatic rd(logic [7:0] a, logic [7:0] e);
        host.acc(1'h0, a, 8'h00);
        #1 chk("read", rd_data, e);
    endtask : rd

    task automatic wr(logic [7:0] a, logic [7:0] v);
        host.acc(1'h1, a, v);
        #1;
    endtask : wr

    task automatic settle(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        reset_i = 1'h1;
        first_cond = 8'h00;
        ovl_cond = 8'h00;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'h0;
        #1 chk("gate", {7'h00, eg}, 8'h01);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h02);
        rd(8'h09, 8'hFF);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h00);
        wr(8'h02, 8'hFF);
        rd(8'h02, 8'hFE);
        // Every timer code twice, other control bits random
        for (int i = 0; i < 16; i++) begin
            d = rnd();
            d[4:2] = i[2:0];
            wr(8'h04, d);
            chk("ctl", {1'h0, bs, as, ft, eg, co}, d & 8'h7F);
            rd(8'h04, d & 8'h7F);
        end
        // Each overload source, enable random, flag must outlive cause
        for (int k = 0; k < 8; k++) begin
            en = rnd();
            wr(8'h03, en);
            rd(8'h03, en);
            @(posedge clk_i) ovl_cond <= 8'h01 << k;
            @(posedge clk_i) ovl_cond <= 8'h00;
            settle(3);
            rd(8'h01, 8'h01 << k);
            chk("irq", {7'h00, irq}, {7'h00, en[k]});
            rd(8'h00, {7'h00, en[k]});
            wr(8'h00, 8'h00);
            settle(2);
            chk("irq", {7'h00, irq}, 8'h00);
            rd(8'h01, 8'h00);
        end
        // Adapter flag interrupts on rise and on fall
        wr(8'h02, 8'h02);
        @(posedge clk_i) first_cond <= 8'h02;
        settle(3);
        chk("irq", {7'h00, irq}, 8'h01);
        wr(8'h00, 8'h00);
        settle(2);
        rd(8'h00, 8'h02);
        @(posedge clk_i) first_cond <= 8'h00;
        settle(3);
        rd(8'h00, 8'h01);
        summarize();
    end
endmodule : pmic_regs_test
`default_nettype wire
